// ---- logic/anasr_pkg.sv ----
// Shared constants and carrier types for the auto-negotiation
// ability and status register slice.
// Assumes a 25 MHz management clock and a same-clock negotiation engine.
package anasr_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register offsets.
  localparam logic [4:0] OFS_LOCAL_ADV = 5'h04;
  localparam logic [4:0] OFS_PARTNER = 5'h05;
  localparam logic [4:0] OFS_EXPANSION = 5'h06;

  // Local advertisement layout and reset value.
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 4;
  localparam logic [4:0] SEL_RESET = 5'h01;
  localparam int ADV_TEN_HALF_BIT = 5;

  // Partner ability layout.
  localparam int PARTNER_NP_BIT = 15;
  localparam int PARTNER_ACK_BIT = 14;
  localparam int PARTNER_RSVD_BIT = 12;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  localparam int PARTNER_RF_BIT = 13;
  localparam int PARTNER_ASYM_BIT = 11;
  localparam int PARTNER_PAUSE_BIT = 10;
  localparam int PARTNER_TECH_MSB = 9;
  localparam int PARTNER_TECH_LSB = 5;
  localparam int PARTNER_SEL_MSB = 4;
  localparam int PARTNER_SEL_LSB = 0;

  // Expansion layout.
  localparam int EXP_LOC_VALID_BIT = 6;
  localparam int EXP_STORE_SEL_BIT = 5;
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LP_NP_BIT = 3;
  localparam int EXP_LOCAL_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LP_AN_BIT = 0;

  // Cycles after reset release before the strap level is trusted.
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // One received link code word from the negotiation engine.
  typedef struct packed {
    logic valid;
    logic next_page;
    logic [15:0] word;
  } anasr_page_t;

  // Levels reported by the negotiation engine.
  typedef struct packed {
    logic parallel_fault;
    logic partner_local_next_page_capable;
    logic partner_an_able;
  } anasr_status_t;

endpackage

// ---- logic/anasr_sync2.sv ----
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the level changes slowly compared with the clock.
`timescale 1ns/100ps
module anasr_sync2 (
  input wire logic clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // Only the second stage is read outside this module.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- logic/anasr_cor_flag.sv ----
// Sticky event flag that software clears by reading it.
// Assumes set and clear are both on the module clock.
`timescale 1ns/100ps
module anasr_cor_flag (
  input wire logic clk,
  input wire logic srst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_d;

  // A set in the clearing cycle wins so no event is dropped.
  always_comb begin
    q_d = set | (q & ~clr);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end

endmodule

// ---- logic/anasr_regs.sv ----
// Auto-negotiation register slice: local advertisement low bits,
// partner base-page ability and expansion status.
// Assumes a same-clock negotiation engine and a strobe register port.
//
// How it works
// - Selector bits 4:0 read/write, reset 00001.
// - Bit 5 advertises ten half, strap default.
// - Capture partner abilities into read-only register.
// - Next pages may update partner register later.
// - Bit 14 shows partner acknowledge from bursts.
// - Bit 15 shows partner next page request.
// - Bit 13 shows partner remote fault.
// - Bits 11,10 show partner pause abilities.
// - Bits 9..5 show partner technology abilities.
// - Bits 4:0 show partner selector, reset zero.
// - Partner bit 12 always reads zero.
// - Expansion bits 15:7 read zero, writes ignored.
// - Expansion bits 6 and 5 read one.
// - Expansion bit 4 shows parallel detect fault.
// - Expansion bit 3 shows partner next page ability.
// - Expansion bit 2 fixed one.
// - Page received bit set, cleared by read.
// - Expansion bit 0 shows partner autoneg ability.
`timescale 1ns/100ps
module anasr_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic strap_ten_half,
  input wire anasr_pkg::anasr_page_t page_in,
  input wire anasr_pkg::anasr_status_t status_in,
  input wire logic an_complete,
  output logic [5:0] adv_word,
  output logic adv_written,
  output logic page_received
);

  logic strap_sync;
  logic [1:0] settle_q;
  logic [4:0] selector_q;
  logic ten_half_q;
  logic adv_touched_q;
  logic [15:0] partner_q;
  logic [15:0] partner_d;
  logic pdf_q;
  logic lp_np_q;
  logic lp_an_q;
  logic base_take;
  logic next_take;
  logic wr_adv;
  logic rd_exp;
  logic [15:0] exp_view;
  logic [15:0] rdata_d;

  // The strap is a pin, so it is synchronised before use.
  anasr_sync2 u_strap_sync (
    .clk(clk),
    .srst(srst),
    .d(strap_ten_half),
    .q(strap_sync)
  );

  // Address decode for the strobes.
  assign wr_adv = reg_wr && (reg_addr == anasr_pkg::OFS_LOCAL_ADV);
  assign rd_exp = reg_rd && (reg_addr == anasr_pkg::OFS_EXPANSION);

  // Strap settle counter; the strap level is caught one count before it saturates.
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_q <= 2'h0;
    end else if (settle_q != anasr_pkg::STRAP_SETTLE_CYCLES) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Protocol selector, writable by software.
  always_ff @(posedge clk) begin
    if (srst) begin
      selector_q <= anasr_pkg::SEL_RESET;
    end else if (wr_adv) begin
      selector_q <= reg_wdata[anasr_pkg::SEL_MSB:anasr_pkg::SEL_LSB];
    end
  end

  // Remembers a write since reset, so the late strap load cannot undo it.
  always_ff @(posedge clk) begin
    if (srst) begin
      adv_touched_q <= 1'b0;
    end else if (wr_adv) begin
      adv_touched_q <= 1'b1;
    end
  end

  // Ten half ability; a software write wins over the late strap load.
  always_ff @(posedge clk) begin
    if (srst) begin
      ten_half_q <= 1'b0;
    end else if (wr_adv) begin
      ten_half_q <= reg_wdata[anasr_pkg::ADV_TEN_HALF_BIT];
    end else if (settle_q == anasr_pkg::STRAP_SETTLE_CYCLES - 2'h1 && !adv_touched_q) begin
      ten_half_q <= strap_sync;
    end
  end

  // Advertised word and write pulse for the negotiation engine.
  // The word follows the register fields one cycle later, so a change
  // is sent two cycles after its write strobe; adv_written marks each write.
  always_ff @(posedge clk) begin
    if (srst) begin
      adv_word <= {1'b0, anasr_pkg::SEL_RESET};
      adv_written <= 1'b0;
    end else begin
      adv_word <= {ten_half_q, selector_q};
      adv_written <= wr_adv;
    end
  end

  // Base page lands whenever one arrives; next pages may overwrite after
  // completion when the partner can exchange them.
  assign base_take = page_in.valid && !page_in.next_page;
  assign next_take = page_in.valid && page_in.next_page && an_complete
                     && status_in.partner_local_next_page_capable;

  // Each field is copied on its own; reserved bit 12 stays low whatever
  // the partner sends.
  always_comb begin
    partner_d = anasr_pkg::PARTNER_RESET;
    partner_d[anasr_pkg::PARTNER_NP_BIT] = page_in.word[anasr_pkg::PARTNER_NP_BIT];
    partner_d[anasr_pkg::PARTNER_ACK_BIT] = page_in.word[anasr_pkg::PARTNER_ACK_BIT];
    partner_d[anasr_pkg::PARTNER_RF_BIT] = page_in.word[anasr_pkg::PARTNER_RF_BIT];
    partner_d[anasr_pkg::PARTNER_ASYM_BIT] =
        page_in.word[anasr_pkg::PARTNER_ASYM_BIT];
    partner_d[anasr_pkg::PARTNER_PAUSE_BIT] =
        page_in.word[anasr_pkg::PARTNER_PAUSE_BIT];
    partner_d[anasr_pkg::PARTNER_TECH_MSB:anasr_pkg::PARTNER_TECH_LSB] =
        page_in.word[anasr_pkg::PARTNER_TECH_MSB:anasr_pkg::PARTNER_TECH_LSB];
    partner_d[anasr_pkg::PARTNER_SEL_MSB:anasr_pkg::PARTNER_SEL_LSB] =
        page_in.word[anasr_pkg::PARTNER_SEL_MSB:anasr_pkg::PARTNER_SEL_LSB];
    partner_d[anasr_pkg::PARTNER_RSVD_BIT] = 1'b0;
  end

  // Partner ability register; all fields but reserved bit 12 come from the code word.
  always_ff @(posedge clk) begin
    if (srst) begin
      partner_q <= anasr_pkg::PARTNER_RESET;
    end else if (base_take) begin
      partner_q <= partner_d;
    end else if (next_take) begin
      partner_q <= partner_d;
    end
  end

  // Status levels from the engine, registered for a clean read view.
  always_ff @(posedge clk) begin
    if (srst) begin
      pdf_q <= 1'b0;
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      pdf_q <= status_in.parallel_fault;
      lp_np_q <= status_in.partner_local_next_page_capable;
      lp_an_q <= status_in.partner_an_able;
    end
  end

  // Page received flag, cleared by reading the expansion register.
  anasr_cor_flag u_page_flag (
    .clk(clk),
    .srst(srst),
    .set(page_in.valid),
    .clr(rd_exp),
    .q(page_received)
  );

  // Expansion view; reserved bits stay zero.
  always_comb begin
    exp_view = 16'h0000;
    exp_view[anasr_pkg::EXP_LOC_VALID_BIT] = 1'b1;
    exp_view[anasr_pkg::EXP_STORE_SEL_BIT] = 1'b1;
    exp_view[anasr_pkg::EXP_PDF_BIT] = pdf_q;
    exp_view[anasr_pkg::EXP_LP_NP_BIT] = lp_np_q;
    exp_view[anasr_pkg::EXP_LOCAL_NP_BIT] = 1'b1;
    exp_view[anasr_pkg::EXP_PAGE_RX_BIT] = page_received;
    exp_view[anasr_pkg::EXP_LP_AN_BIT] = lp_an_q;
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    if (reg_addr == anasr_pkg::OFS_LOCAL_ADV) begin
      rdata_d = {10'h000, ten_half_q, selector_q};
    end else if (reg_addr == anasr_pkg::OFS_PARTNER) begin
      rdata_d = partner_q;
    end else if (reg_addr == anasr_pkg::OFS_EXPANSION) begin
      rdata_d = exp_view;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks follow; they share one clock and one reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_sel_reset;
    $fell(srst) |-> selector_q == anasr_pkg::SEL_RESET;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("Selector does not hold its reset pattern.");

  property p_sel_write;
    wr_adv ##1 !wr_adv ##1 (reg_rd && reg_addr == anasr_pkg::OFS_LOCAL_ADV)
      |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Selector readback differs from written value.");

  property p_ten_half_write;
    wr_adv |=> ten_half_q == $past(reg_wdata[anasr_pkg::ADV_TEN_HALF_BIT]);
  endproperty
  a_ten_half_write: assert property (p_ten_half_write)
    else $error("Ten half bit ignored a write.");

  property p_adv_out;
    wr_adv |-> ##2 adv_word == {$past(reg_wdata[5:0], 2)};
  endproperty
  a_adv_out: assert property (p_adv_out)
    else $error("Advertised word lags a write by more than two cycles.");

  property p_base_capture;
    base_take |=> partner_q == ($past(page_in.word) & 16'hefff);
  endproperty
  a_base_capture: assert property (p_base_capture)
    else $error("Base page not captured into partner register.");

  // Writes to the read-only offsets must leave the partner word alone.
  property p_ro_write;
    reg_wr && reg_addr != anasr_pkg::OFS_LOCAL_ADV && !page_in.valid |=> $stable(partner_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("Write changed the partner ability register.");

  property p_next_page;
    page_in.valid && page_in.next_page && !an_complete && !base_take
      |=> $stable(partner_q);
  endproperty
  a_next_page: assert property (p_next_page)
    else $error("Next page overwrote partner register before completion.");

  property p_ack_read;
    reg_rd && reg_addr == anasr_pkg::OFS_PARTNER
      |=> reg_rdata[15:13] == $past(partner_q[15:13]);
  endproperty
  a_ack_read: assert property (p_ack_read)
    else $error("Partner ack, next page or fault bit misreported.");

  property p_rsvd_zero;
    partner_q[anasr_pkg::PARTNER_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Partner reserved bit is set.");

  property p_np_field;
    (base_take || next_take) |=> partner_q[15] == $past(page_in.word[15]);
  endproperty
  a_np_field: assert property (p_np_field)
    else $error("Partner next page request bit misreported.");

  property p_rf_field;
    (base_take || next_take) |=> partner_q[13] == $past(page_in.word[13]);
  endproperty
  a_rf_field: assert property (p_rf_field)
    else $error("Partner remote fault bit misreported.");

  property p_pause_field;
    (base_take || next_take) |=> partner_q[11:10] == $past(page_in.word[11:10]);
  endproperty
  a_pause_field: assert property (p_pause_field)
    else $error("Partner pause bits misreported.");

  property p_tech_field;
    (base_take || next_take) |=> partner_q[9:5] == $past(page_in.word[9:5]);
  endproperty
  a_tech_field: assert property (p_tech_field)
    else $error("Partner technology bits misreported.");

  property p_sel_field;
    (base_take || next_take) |=> partner_q[4:0] == $past(page_in.word[4:0]);
  endproperty
  a_sel_field: assert property (p_sel_field)
    else $error("Partner selector field misreported.");

  property p_exp_fixed;
    rd_exp |=> reg_rdata[15:7] == 9'h000 && reg_rdata[6:5] == 2'h3
      && reg_rdata[2];
  endproperty
  a_exp_fixed: assert property (p_exp_fixed)
    else $error("Expansion fixed bits read wrong.");

  // The registered fault level trails the engine by exactly one cycle.
  property p_pdf_level;
    1'b1 |=> pdf_q == $past(status_in.parallel_fault);
  endproperty
  a_pdf_level: assert property (p_pdf_level)
    else $error("Parallel detect fault level not registered.");

  property p_pdf_read;
    rd_exp |=> reg_rdata[anasr_pkg::EXP_PDF_BIT] == $past(status_in.parallel_fault, 2);
  endproperty
  a_pdf_read: assert property (p_pdf_read)
    else $error("Parallel detect fault bit does not follow the engine.");

  property p_lp_np_read;
    rd_exp |=> reg_rdata[3] == $past(status_in.partner_local_next_page_capable, 2);
  endproperty
  a_lp_np_read: assert property (p_lp_np_read)
    else $error("Partner next page ability bit does not follow the engine.");

  property p_lp_an_read;
    rd_exp |=> reg_rdata[0] == $past(status_in.partner_an_able, 2);
  endproperty
  a_lp_an_read: assert property (p_lp_an_read)
    else $error("Partner autoneg ability bit does not follow the engine.");

  property p_page_clear;
    page_received && rd_exp && !page_in.valid |=> !page_received;
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("Page received flag survived a read.");

  property p_page_set;
    page_in.valid |=> page_received;
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("Page received flag not set by a code word.");

  property p_page_keep;
    page_in.valid && rd_exp |=> page_received ##1 (rd_exp || page_received);
  endproperty
  a_page_keep: assert property (p_page_keep)
    else $error("Page received event lost during a read.");

  c_base_page: cover property (base_take ##[1:20] rd_exp);
  c_next_page: cover property (next_take);
  c_race: cover property (page_in.valid && rd_exp);
  c_strap: cover property ($fell(srst) ##[1:6] ten_half_q);

endmodule

// ---- tb/anasr_partner.sv ----
// Link partner model: hands received code words and status levels to the slice.
// Assumes the slice samples page_in on the rising edge of clk.
`timescale 1ns/100ps
module anasr_partner (
  input wire logic clk,
  output anasr_pkg::anasr_page_t page,
  output anasr_pkg::anasr_status_t status,
  output logic an_complete
);
  // Quiet line at start: no page, no abilities, negotiation not complete.
  initial begin
    page = '0;
    status = '0;
    an_complete = 1'b0;
  end

  // One-cycle page, launched just after an edge; the word is inverted once the
  // pulse ends so a stale copy can never pass for a fresh capture.
  task automatic send_page(input logic np, input logic [15:0] w);
    page <= '{valid: 1'b1, next_page: np, word: w};
    @(posedge clk);
    page <= '{valid: 1'b0, next_page: 1'b0, word: ~w};
    @(posedge clk);
  endtask

  // Status levels and completion change together, then hold.
  task automatic set_status(input logic [2:0] s, input logic done);
    status <= s;
    an_complete <= done;
    @(posedge clk);
  endtask
endmodule

// ---- tb/anasr_regs_tb_top.sv ----
// Self-checking bench for the auto-negotiation register slice.
// Assumes the strobe register port and the partner model beside it.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end \
end
module anasr_regs_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic strap_ten_half = 1'b1;
  anasr_pkg::anasr_page_t page_in;
  anasr_pkg::anasr_status_t status_in;
  logic an_complete;
  logic [5:0] adv_word;
  logic adv_written;
  logic page_received;
  logic wr_seen;
  logic [15:0] rd_q;
  int mismatches = 0;
  int checked = 0;

  // Half period of 20 ns gives the 25 MHz clock.
  always #20 clk = ~clk;

  anasr_regs u_anasr_regs (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_ten_half(strap_ten_half), .page_in(page_in), .status_in(status_in),
    .an_complete(an_complete), .adv_word(adv_word), .adv_written(adv_written),
    .page_received(page_received)
  );

  anasr_partner u_anasr_partner (
    .clk(clk), .page(page_in), .status(status_in), .an_complete(an_complete)
  );

  // Write: one strobe cycle, then one idle edge so strobes never collide.
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 wr_seen = adv_written;
    @(posedge clk);
  endtask

  // Read: the data stands only in the cycle after the strobe, so sample there.
  task automatic chk_read(input logic [4:0] a, input logic [15:0] e, input string nm);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
    `CHK(nm, e, rd_q)
    @(posedge clk);
  endtask

  // Bounded wait for the page flag; running out ends the run as a failure.
  task automatic wait_flag();
    for (int i = 0; i < 4; i++) begin
      if (page_received === 1'b1) begin
        return;
      end
      @(posedge clk);
    end
    mismatches++;
    $display("Error page_received expected 1 seen %b", page_received);
    print_verdict();
  endtask

  task automatic print_verdict();
    $display("Counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0000, "partner reset");
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h0064, "exp reset");
    chk_read(anasr_pkg::OFS_LOCAL_ADV, 16'h0021, "adv reset");
    `CHK("adv_word reset", 6'h21, adv_word)
    $display("Test reset values done");
    // Advert change made before completion; the partner sends a base page below.
    reg_write(anasr_pkg::OFS_LOCAL_ADV, 16'hffde);
    `CHK("adv_written", 1'b1, wr_seen)
    chk_read(anasr_pkg::OFS_LOCAL_ADV, 16'h001e, "adv write");
    `CHK("adv_word", 6'h1e, adv_word)
    reg_write(anasr_pkg::OFS_PARTNER, 16'hffff);
    reg_write(anasr_pkg::OFS_EXPANSION, 16'hffff);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0000, "partner ro");
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h0064, "exp ro");
    chk_read(5'h1f, 16'h0000, "unmapped");
    $display("Test register access done");
    u_anasr_partner.send_page(1'b0, 16'hffff);
    wait_flag();
    chk_read(anasr_pkg::OFS_PARTNER, 16'hefff, "base page");
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h0066, "page flag");
    `CHK("flag cleared", 1'b0, page_received)
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h0064, "flag read");
    u_anasr_partner.send_page(1'b0, 16'h0ca5);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0ca5, "fields");
    $display("Test base page done");
    u_anasr_partner.send_page(1'b1, 16'h1234);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0ca5, "early next");
    u_anasr_partner.set_status(3'b111, 1'b1);
    u_anasr_partner.send_page(1'b1, 16'h1234);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0234, "next page");
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h007f, "status");
    $display("Test next page done");
    fork
      chk_read(anasr_pkg::OFS_EXPANSION, 16'h007d, "race read");
      u_anasr_partner.send_page(1'b0, 16'h5a5a);
    join
    `CHK("flag kept", 1'b1, page_received)
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h007f, "flag kept rd");
    u_anasr_partner.set_status(3'b000, 1'b0);
    chk_read(anasr_pkg::OFS_EXPANSION, 16'h0064, "status low");
    $display("Test coincident event done");
    // Mid-run reset with the strap low; the partner word must clear too.
    strap_ten_half <= 1'b0;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_read(anasr_pkg::OFS_PARTNER, 16'h0000, "partner re-reset");
    chk_read(anasr_pkg::OFS_LOCAL_ADV, 16'h0001, "strap low");
    `CHK("adv_word strap", 6'h01, adv_word)
    $display("Test strap low done");
    print_verdict();
  end
endmodule
